/* File: verilog/dio_regs.svh */
// register offsets, field positions and reset values of the digital channel block
// assumes a 32-bit wide plain register port, byte addresses
`ifndef DIO_REGS_SVH
`define DIO_REGS_SVH
`define DIO_NCH 8
`define DIO_ADDR_W 8
`define DIO_CTRL_OFS 8'h00
`define DIO_DIR_OFS 8'h04
`define DIO_CMD_OFS 8'h08
`define DIO_USED_OFS 8'h0c
`define DIO_INPUT_OFS 8'h10
`define DIO_OVL_OFS 8'h14
`define DIO_ACTIVE_OFS 8'h18
`define DIO_DRIVE_OFS 8'h1c
`define DIO_CTRL_OE_BIT 0
`define DIO_CTRL_RUN_BIT 1
`define DIO_CTRL_RST 2'h0
`define DIO_CH_RST 8'h00
`endif

/* File: verilog/dio_pkg.sv */
// types shared by the digital channel block
// assumes the constants header is included by users as well
package dio_pkg;
  typedef logic [7:0] chan_t;
  typedef logic [31:0] word_t;
endpackage

/* File: verilog/digital_io_channel_control.sv */
// eight-channel digital terminal control: direction, commands, overload latch, indicators
// assumes synchronous pin inputs, a one-cycle task boundary pulse and a plain register port
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "dio_regs.svh"

module digital_io_channel_control
  import dio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic task_tick,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] term_in,
  input wire logic [7:0] overload_in,
  output logic [7:0] drive_out,
  output logic outputs_enabled,
  output logic global_output_enable_indicator,
  output logic [7:0] channel_status_indicators
);

  // register state
  logic [1:0] ctrl_q;
  chan_t dir_q;
  chan_t cmd_stage_q;
  chan_t cmd_q;
  chan_t used_q;
  chan_t in_q;
  chan_t ovl_q;
  chan_t drive_q;
  chan_t ind_q;
  logic oe_q;
  word_t rdata_q;

  // address decode
  wire ce_wr = clk_en & reg_wr;
  wire wr_ctrl = ce_wr & (reg_addr == `DIO_CTRL_OFS);
  wire wr_dir = ce_wr & (reg_addr == `DIO_DIR_OFS);
  wire wr_cmd = ce_wr & (reg_addr == `DIO_CMD_OFS);
  wire wr_used = ce_wr & (reg_addr == `DIO_USED_OFS);
  wire oe_en = ctrl_q[`DIO_CTRL_OE_BIT];
  wire run = ctrl_q[`DIO_CTRL_RUN_BIT];

  // per-channel combinational terms
  chan_t ovl_set;
  chan_t ovl_clr;
  chan_t drive_d;
  chan_t in_d;
  chan_t ind_d;
  chan_t ovl_d;

  genvar g;
  generate
    for (g = 0; g < `DIO_NCH; g++) begin : g_ch
      // overload trips only a channel set as output
      assign ovl_set[g] = dir_q[g] & overload_in[g];
      // release needs command 0 and a quiet overload line
      assign ovl_clr[g] = ~cmd_q[g] & ~overload_in[g];
      // set wins over clear in the same cycle
      assign ovl_d[g] = ovl_set[g] | (ovl_q[g] & ~ovl_clr[g]);
      // driver on only with enable, command, no latch and no live fault
      assign drive_d[g] = dir_q[g] & cmd_q[g] & oe_en & ~ovl_d[g];
      // output channels read back their own driver
      assign in_d[g] = dir_q[g] ? drive_q[g] : term_in[g];
      // indicators use internal state only, never the load supply
      assign ind_d[g] = run &
        (dir_q[g] ? cmd_q[g] : (in_q[g] & used_q[g]));
    end
  endgenerate

  // control and configuration registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `DIO_CTRL_RST;
      dir_q <= `DIO_CH_RST;
      cmd_stage_q <= `DIO_CH_RST;
      used_q <= `DIO_CH_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata[1:0];
      if (wr_dir) dir_q <= reg_wdata[7:0];
      if (wr_cmd) cmd_stage_q <= reg_wdata[7:0];
      if (wr_used) used_q <= reg_wdata[7:0];
    end
  end

  // task-boundary sampling of commands and inputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= `DIO_CH_RST;
      in_q <= `DIO_CH_RST;
    end else if (clk_en && task_tick) begin
      cmd_q <= cmd_stage_q;
      in_q <= in_d;
    end
  end

  // overload latch, drivers and indicators
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ovl_q <= `DIO_CH_RST;
      drive_q <= `DIO_CH_RST;
      ind_q <= `DIO_CH_RST;
      oe_q <= 1'b0;
    end else if (clk_en) begin
      ovl_q <= ovl_d;
      drive_q <= drive_d;
      ind_q <= ind_d;
      oe_q <= oe_en;
    end
  end

  // read data selection, unmapped reads return zero
  word_t rsel;
  assign rsel =
    (reg_addr == `DIO_CTRL_OFS) ? {30'h0, ctrl_q} :
    (reg_addr == `DIO_DIR_OFS) ? {24'h0, dir_q} :
    (reg_addr == `DIO_CMD_OFS) ? {24'h0, cmd_stage_q} :
    (reg_addr == `DIO_USED_OFS) ? {24'h0, used_q} :
    (reg_addr == `DIO_INPUT_OFS) ? {24'h0, in_q} :
    (reg_addr == `DIO_OVL_OFS) ? {24'h0, ovl_q} :
    (reg_addr == `DIO_ACTIVE_OFS) ? {24'h0, cmd_q} :
    (reg_addr == `DIO_DRIVE_OFS) ? {24'h0, drive_q} : 32'h0;

  // read data stand for one enabled cycle only, and hold while clock enable is low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
    end else if (clk_en) begin
      rdata_q <= reg_rd ? rsel : 32'h0;
    end
  end

  assign reg_rdata = rdata_q;
  assign drive_out = drive_q;
  assign outputs_enabled = oe_q;
  assign global_output_enable_indicator = oe_q;
  assign channel_status_indicators = ind_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // a fault on any output channel in this cycle
  sequence s_fault;
    clk_en && ovl_set != 8'h00;
  endsequence

  // a tripped latch seeing command zero and a quiet overload line
  sequence s_release(int ch);
    clk_en && ovl_q[ch] && !cmd_q[ch] && !overload_in[ch];
  endsequence

  // indicators against run, inputs and the applied command, drivers against the enable bit
  chk_ind_stopped: assert property ((clk_en && !run) |=> ind_q == 8'h00)
    else $error("indicator lit while program stopped");
  chk_ind_input: assert property ((clk_en && run && !dir_q[0] && in_q[0] && used_q[0])
    |=> ind_q[0])
    else $error("used input high but indicator dark");
  chk_ind_output: assert property ((clk_en && run && dir_q[1])
    |=> ind_q[1] == $past(cmd_q[1]))
    else $error("output indicator differs from command");
  chk_oe_gate: assert property ((clk_en && !oe_en)
    |=> drive_q == 8'h00 && oe_q == 1'b0)
    else $error("driver on while outputs disabled");
  // overload latch set, hold and release
  chk_ovl_trip: assert property (s_fault |=>
    (drive_q & $past(ovl_set)) == 8'h00 && (ovl_q & $past(ovl_set)) == $past(ovl_set))
    else $error("overload did not latch driver off");
  chk_ovl_hold: assert property ((clk_en && ovl_q[2] && cmd_q[2])
    |=> ovl_q[2] && !drive_q[2])
    else $error("latch released under command one");
  chk_ovl_release: assert property (s_release(3) |=> !ovl_q[3])
    else $error("latch not released by command zero");
  // task boundary and feedback
  chk_cmd_tick: assert property ((clk_en && !task_tick) |=> $stable(cmd_q))
    else $error("command changed between task boundaries");
  chk_feedback: assert property ((clk_en && task_tick && dir_q[4])
    |=> in_q[4] == $past(drive_q[4]))
    else $error("output not fed back to input");
  // register port answers
  chk_read_ovl: assert property ((clk_en && reg_rd && reg_addr == `DIO_OVL_OFS)
    |=> reg_rdata == {24'h0, $past(ovl_q)})
    else $error("overload status read wrong");
  chk_rdata_idle: assert property ((clk_en && !reg_rd) |=> reg_rdata == 32'h0)
    else $error("read data stand without a read");
  // a low enable holds every register, read data included
  chk_ce_freeze: assert property (!clk_en |=> $stable(cmd_q) && $stable(ovl_q)
    && $stable(drive_q) && $stable(ind_q) && $stable(reg_rdata))
    else $error("state moved while clock enable low");
  // enable output and its indicator follow the control bit together
  chk_oe_follow: assert property (clk_en |=> outputs_enabled == $past(oe_en)
    && global_output_enable_indicator == outputs_enabled)
    else $error("outputs enabled signal out of step");

  // per-channel checks, so every terminal is covered and not one sample channel
  for (genvar k = 0; k < `DIO_NCH; k++) begin : g_chk
    // an unused or low input keeps its indicator dark
    chk_ind_dark: assert property (@(posedge ref_clk) disable iff (!rstn)
      (clk_en && !dir_q[k] && !(in_q[k] && used_q[k])) |=> !ind_q[k])
      else $error("input indicator lit without a used high input");
    // an output indicator follows the applied command, enabled or not
    chk_ind_cmd: assert property (@(posedge ref_clk) disable iff (!rstn)
      (clk_en && run && dir_q[k]) |=> ind_q[k] == $past(cmd_q[k]))
      else $error("output indicator differs from applied command");
    // a live fault on an output keeps its driver off and sets the latch
    chk_ovl_live: assert property (@(posedge ref_clk) disable iff (!rstn)
      (clk_en && dir_q[k] && overload_in[k]) |=> ovl_q[k] && !drive_q[k])
      else $error("driver on during live overload");
    // a driver conducts only on an enabled, unlatched output commanded to one
    chk_drive_src: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en |=> !drive_q[k] || ($past(dir_q[k]) && $past(cmd_q[k])
      && $past(oe_en) && !$past(ovl_q[k])))
      else $error("driver on without an enabled commanded output");
    // an input channel samples its terminal at the task boundary
    chk_in_sample: assert property (@(posedge ref_clk) disable iff (!rstn)
      (clk_en && task_tick && !dir_q[k]) |=> in_q[k] == $past(term_in[k]))
      else $error("input sample differs from terminal");
  end

endmodule

/* File: sim/field_model.sv */
// field side: sensors on inputs, loads on outputs
// assumes the bench picks sensor levels and shorted loads
`timescale 1ns/1ps
module field_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] drive_out,
  input wire logic [7:0] sensor_lvl,
  input wire logic [7:0] short_mask,
  output logic [7:0] term_in,
  output logic [7:0] overload_in
);
  // a shorted load trips only while its driver conducts
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      term_in <= 8'h00;
      overload_in <= 8'h00;
    end else begin
      term_in <= sensor_lvl;
      overload_in <= short_mask & drive_out;
    end
  end
endmodule

/* File: sim/digital_io_channel_control_tb.sv */
// self-checking bench for the digital channel block
// assumes the field model on the terminal side, 100 MHz clock
`timescale 1ns/1ps
`include "dio_regs.svh"
module digital_io_channel_control_tb;
  import dio_pkg::*;
  logic ref_clk, rstn, tick, wr, rd, oe, oei, ce;
  logic [7:0] addr;
  word_t wdata, rdata, d;
  chan_t drv, sen, sht, ovl, tin, ind, dir, used, cmd, pdrv;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  digital_io_channel_control dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(ce),
    .task_tick(tick), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .term_in(tin), .overload_in(ovl), .drive_out(drv),
    .outputs_enabled(oe), .global_output_enable_indicator(oei),
    .channel_status_indicators(ind));
  field_model fm (.ref_clk(ref_clk), .rstn(rstn), .drive_out(drv), .sensor_lvl(sen),
    .short_mask(sht), .term_in(tin), .overload_in(ovl));
  // compare and count
  task automatic chk(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // bus cycles and one task boundary
  task automatic wreg(input logic [7:0] a, input word_t v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tk;
    @(posedge ref_clk);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // expected indicators
  function automatic chan_t e_ind(input logic run, input chan_t c, input chan_t s);
    return run ? ((c & dir) | (s & used & ~dir)) : 8'h00;
  endfunction
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      results();
    end
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    tick = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = '0;
    sen = 8'h00;
    sht = 8'h00;
    pdrv = 8'h00;
    void'($urandom(32'h5344876e));
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    #1 chk(ind, 0);
    dir = 8'($urandom);
    used = 8'($urandom);
    wreg(`DIO_DIR_OFS, dir);
    wreg(`DIO_USED_OFS, used);
    wreg(`DIO_CTRL_OFS, 32'h3);
    for (int i = 0; i < 8; i++) begin
      cmd = (i == 0) ? 8'hff : 8'($urandom);
      sen <= 8'($urandom);
      wreg(`DIO_CMD_OFS, cmd);
      repeat (2) @(posedge ref_clk);
      #1 chk(drv, pdrv);
      tk();
      chk(drv, cmd & dir);
      chk(ind, e_ind(1'b1, cmd, sen));
      rreg(`DIO_INPUT_OFS);
      chk(d, (pdrv & dir) | (sen & ~dir));
      pdrv = cmd & dir;
    end
    $display("test commands done");
    wreg(`DIO_CTRL_OFS, 32'h2);
    repeat (3) @(posedge ref_clk);
    #1 chk(drv, 0);
    chk({oe, oei}, 0);
    chk(ind, e_ind(1'b1, cmd, sen));
    wreg(`DIO_CTRL_OFS, 32'h1);
    repeat (3) @(posedge ref_clk);
    #1 chk(ind, 0);
    $display("test enable and run done");
    wreg(`DIO_DIR_OFS, 32'h1);
    wreg(`DIO_CMD_OFS, 32'h1);
    wreg(`DIO_CTRL_OFS, 32'h3);
    tk();
    chk(drv, 1);
    chk({oe, oei}, 32'h3);
    sht <= 8'h01;
    repeat (4) @(posedge ref_clk);
    #1 chk(drv, 0);
    rreg(`DIO_OVL_OFS);
    chk(d, 1);
    sht <= 8'h00;
    tk();
    chk(drv, 0);
    wreg(`DIO_CMD_OFS, 32'h0);
    tk();
    rreg(`DIO_OVL_OFS);
    chk(d, 0);
    wreg(`DIO_CMD_OFS, 32'h1);
    tk();
    chk(drv, 1);
    rreg(8'h40);
    chk(d, 0);
    $display("test overload done");
    // enable low: strobes and ticks are ignored, every state holds
    @(posedge ref_clk);
    ce <= 1'b0;
    wreg(`DIO_CMD_OFS, 32'h0);
    tk();
    chk(drv, 1);
    @(posedge ref_clk);
    ce <= 1'b1;
    rreg(`DIO_CMD_OFS);
    chk(d, 1);
    rreg(`DIO_ACTIVE_OFS);
    chk(d, 1);
    rreg(`DIO_DRIVE_OFS);
    chk(d, 1);
    @(posedge ref_clk);
    #1 chk(rdata, 0);
    $display("test freeze done");
    results();
  end
endmodule
